/* File: dv/pmc_chk.sv */
`default_nettype none
`include "pmc_regs.svh"
// bus and readback checks seen at the block pins
module pmc_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_take; // read accepted at this edge
    logic wr_take; // write accepted at this edge
    logic rd_pend_ff; // read answer still due
    logic [7:0] rd_addr_ff; // decoded address of that read
    logic rd_done; // read data standing on hrdata
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    assign wr_take = hsel && hready && htrans[1] && hwrite;
    assign rd_done = rd_pend_ff && hreadyout;
    // track the read so its data can be judged by address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_ff <= 1'b0;
            rd_addr_ff <= 8'h00;
        end else begin
            rd_pend_ff <= rd_take || (rd_pend_ff && !hreadyout);
            if (rd_take) begin
                rd_addr_ff <= haddr[7:0];
            end
        end
    end
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_rd_wait;
        rd_take |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_wr_nowait;
        wr_take |=> hreadyout;
    endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    property p_hold;
        hreadyout && $past(hreadyout) |-> $stable(hrdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_cmd_b15;
        rd_done && rd_addr_ff[3:0] == 4'h0 && rd_addr_ff < 8'h20
            |-> hrdata[15] == 1'b0;
    endproperty
    a_cmd_b15: assert property (p_cmd_b15) else $error("bit 15 set");
    property p_unmapped;
        rd_done && (rd_addr_ff >= 8'h2C || rd_addr_ff[3:0] == 4'hC)
            |-> hrdata == `PMC_WORD_ZERO;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("hole not zero");
    property p_clr_rd;
        rd_done && rd_addr_ff == `PMC_ADDR_INT_CLR |-> hrdata == 32'h0;
    endproperty
    a_clr_rd: assert property (p_clr_rd) else $error("clear reg read");
    property p_sts_rsv;
        rd_done && rd_addr_ff == `PMC_ADDR_STATUS
            |-> (hrdata & 32'hFFFF_FCFC) == 32'h0;
    endproperty
    a_sts_rsv: assert property (p_sts_rsv) else $error("status bits");
    c_read: cover property (rd_done);
    c_write: cover property (wr_take);
    c_irq: cover property ($rose(irq));
endmodule // pmc_chk
bind pmc_top pmc_chk pmc_chk_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq));
`default_nettype wire

/* File: dv/pmc_tb_top.sv */
`default_nettype none
`include "pmc_regs.svh"
// self-checking bench: ahb master, event pins, checks
module pmc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd, lfsr, v, n;
    logic [1:0] htrans, inc_evt_in, dec_evt_in;
    logic [7:0] b; // base of counter under test
    int num_errors, n_tests;
    pmc_top pmc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .inc_evt_in(inc_evt_in),
        .dec_evt_in(dec_evt_in), .irq(irq));
    // 40 MHz clock
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // random source, fixed start
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // command word: condition code and opcode only
    function automatic logic [31:0] cw(input logic [3:0] op,
                                       input logic [2:0] cc);
        return {8'h00, cc, 1'b0, op, 16'h0000};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                     exp);
            num_errors++;
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // wait for hready sampled high, bounded
    task automatic rdy;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 64);
        if (k >= 64) begin
            num_errors++;
            results();
        end
    endtask
    // one single word transfer; read data left in rd
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= `PMC_HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        rd = hrdata;
    endtask
    task automatic wrt(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // event level held for c cycles, then let the pins settle
    task automatic evt(input int i, input logic up, input logic [31:0] c);
        @(posedge hclk);
        if (up) inc_evt_in[i] <= 1'b1;
        else dec_evt_in[i] <= 1'b1;
        repeat (c) @(posedge hclk);
        inc_evt_in <= 2'h0;
        dec_evt_in <= 2'h0;
        repeat (10) @(posedge hclk);
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge hclk);
        check({31'h0, irq}, {31'h0, e});
    endtask
    // watchdog on the whole run
    initial begin
        repeat (100000) @(posedge hclk);
        num_errors++;
        results();
    end
    initial begin
        {hresetn, hsel, hwrite, htrans, inc_evt_in, dec_evt_in} = '0;
        {haddr, hwdata} = '0;
        lfsr = 32'hF42E5A33;
        num_errors = 0;
        n_tests = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(8'h00, 32'h0);
        rdc(8'h08, 32'h0);
        rdc(8'h20, 32'h0);
        rdc(8'h28, 32'h0);
        // holes swallow writes and read zero
        wrt(8'h30, 32'hFFFFFFFF);
        rdc(8'h30, 32'h0);
        rdc(8'h0C, 32'h0);
        $display("test reset done");
        // pins are the selected events, both idle before start
        wrt(8'h00, cw(pmc_pkg::PMC_OPC_START, 3'h0));
        evt(0, 1'b1, 32'h5);
        rdc(8'h08, 32'h5);
        wrt(8'h00, cw(pmc_pkg::PMC_OPC_STOP, 3'h0));
        evt(0, 1'b1, 32'h4);
        rdc(8'h08, 32'h5);
        wrt(8'h00, cw(pmc_pkg::PMC_OPC_START, 3'h0));
        evt(0, 1'b0, 32'h3);
        rdc(8'h08, 32'h2);
        wrt(8'h00, cw(pmc_pkg::PMC_OPC_SAMPLE, 3'h0));
        rdc(8'h04, 32'h2);
        evt(0, 1'b1, 32'h3);
        rdc(8'h08, 32'h5);
        wrt(8'h04, 32'h100);
        wrt(8'h00, cw(pmc_pkg::PMC_OPC_SAMPLE, 3'h2));
        rdc(8'h04, 32'h100);
        wrt(8'h00, cw(4'h3, 3'h0) | 32'h8000);
        rdc(8'h00, cw(4'h3, 3'h0));
        evt(0, 1'b1, 32'h2);
        rdc(8'h08, 32'h7);
        wrt(8'h00, cw(pmc_pkg::PMC_OPC_SAMP_RST, 3'h0));
        rdc(8'h04, 32'h7);
        evt(0, 1'b1, 32'h2);
        rdc(8'h08, 32'h2);
        wrt(8'h00, cw(pmc_pkg::PMC_OPC_RESET, 3'h0));
        rdc(8'h20, 32'h0);
        evt(0, 1'b1, 32'h3);
        rdc(8'h08, 32'h0);
        $display("test opcodes done");
        wrt(8'h00, cw(pmc_pkg::PMC_OPC_START, 3'h0));
        evt(0, 1'b0, 32'h2);
        rdc(8'h08, 32'hFFFFFFFE);
        wrt(8'h14, 32'hFFFFFFFE);
        wrt(8'h10, cw(pmc_pkg::PMC_OPC_PRELOAD, 3'h0));
        rdc(8'h18, 32'hFFFFFFFE);
        rdc(8'h20, 32'h101);
        wrt(8'h10, cw(pmc_pkg::PMC_OPC_START, 3'h0));
        evt(1, 1'b1, 32'h3);
        rdc(8'h18, 32'h1);
        rdc(8'h20, 32'h303);
        // interrupt masked, enabled, cleared
        irq_is(1'b0);
        wrt(8'h28, 32'h2);
        irq_is(1'b1);
        wrt(8'h24, 32'h2);
        irq_is(1'b0);
        rdc(8'h20, 32'h301);
        wrt(8'h14, 32'h1000);
        wrt(8'h10, cw(pmc_pkg::PMC_OPC_PRELOAD, 3'h0));
        evt(1, 1'b1, 32'h4);
        rdc(8'h18, 32'h1004);
        $display("test overflow done");
        for (int i = 0; i < 4; i++) begin
            b = i[0] ? 8'h10 : 8'h00;
            lfsr = nxt(lfsr);
            v = lfsr;
            lfsr = nxt(lfsr);
            n = {28'h0, lfsr[3:0]} + 32'h2;
            wrt(b, cw(pmc_pkg::PMC_OPC_RESET, 3'h0));
            wrt(b + 8'h04, v);
            wrt(b, cw(pmc_pkg::PMC_OPC_PRELOAD, 3'h0));
            wrt(b, cw(pmc_pkg::PMC_OPC_START, 3'h0));
            evt(i % 2, lfsr[4], n);
            rdc(b + 8'h08, lfsr[4] ? v + n : v - n);
            lfsr = nxt(lfsr);
            v = {lfsr[31:20], 4'h0, lfsr[15:0]};
            wrt(b, v);
            rdc(b, v & `PMC_CMD_RSVD_MASK);
        end
        $display("test random done");
        results();
    end
endmodule // pmc_tb_top
`default_nettype wire

/* File: rtl/pmc_counter.sv */
`default_nettype none
`include "pmc_regs.svh"
// one 32-bit event counter with opcode execution
module pmc_counter (
    input wire logic hclk,
    input wire logic hresetn,
    pmc_ctr_if.ctr cif
);
    pmc_pkg::pmc_word_t count_ff; // live count
    pmc_pkg::pmc_word_t data_ff; // sample / preload / threshold register
    logic run_ff; // counting enabled
    logic ovf_ff; // wrap pulse
    logic up; // net increment this cycle
    logic dn; // net decrement this cycle
    logic samp_ok; // sample may overwrite data

    // simultaneous inc and dec cancel out
    assign up = cif.inc_evt && !cif.dec_evt;
    assign dn = cif.dec_evt && !cif.inc_evt;
    assign samp_ok = (cif.cc == `PMC_CC_FALSE);

    // run flag follows stop, start, reset, restart
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_ff <= 1'b0;
        end else if (cif.cmd_wr) begin
            case (cif.opcode)
                `PMC_OP_STOP: run_ff <= 1'b0;
                `PMC_OP_START: run_ff <= 1'b1;
                `PMC_OP_RESET: run_ff <= 1'b0;
                `PMC_OP_SAMP_RST: run_ff <= 1'b1;
                default: run_ff <= run_ff;
            endcase
        end
    end

    // count update: reset, sample-and-restart and preload commands win over events in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_ff <= `PMC_WORD_ZERO;
            ovf_ff <= 1'b0;
        end else begin
            ovf_ff <= 1'b0;
            if (cif.cmd_wr && (cif.opcode == `PMC_OP_RESET ||
                               cif.opcode == `PMC_OP_SAMP_RST)) begin
                count_ff <= `PMC_WORD_ZERO;
            end else if (cif.cmd_wr && cif.opcode == `PMC_OP_PRELOAD) begin
                count_ff <= data_ff;
            end else if (run_ff && up) begin
                count_ff <= count_ff + `PMC_WORD_ONE;
                ovf_ff <= (count_ff == `PMC_WORD_ONES);
            end else if (run_ff && dn) begin
                count_ff <= count_ff - `PMC_WORD_ONE;
                ovf_ff <= (count_ff == `PMC_WORD_ZERO);
            end
        end
    end

    // data register: software write or sample
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_ff <= `PMC_WORD_ZERO;
        end else if (cif.data_wr) begin
            data_ff <= cif.wdata;
        end else if (cif.cmd_wr && samp_ok &&
                     (cif.opcode == `PMC_OP_SAMPLE ||
                      cif.opcode == `PMC_OP_SAMP_RST)) begin
            data_ff <= count_ff;
        end
    end

    assign cif.count = count_ff;
    assign cif.data = data_ff;
    assign cif.running = run_ff;
    assign cif.ovf = ovf_ff;
endmodule // pmc_counter
`default_nettype wire

/* File: rtl/pmc_ctr_if.sv */
`default_nettype none
// bundle between register slave and one counter
interface pmc_ctr_if;
    logic cmd_wr; // command register written, one cycle
    logic [3:0] opcode; // opcode of that write
    logic [2:0] cc; // threshold condition code of that write
    logic data_wr; // data register written by software
    pmc_pkg::pmc_word_t wdata; // write data
    logic inc_evt; // selected increment event level
    logic dec_evt; // selected decrement event level
    pmc_pkg::pmc_word_t count; // live count
    pmc_pkg::pmc_word_t data; // data register
    logic running; // counter running
    logic ovf; // wrap pulse
    modport ctr (input cmd_wr, opcode, cc, data_wr, wdata, inc_evt, dec_evt,
                 output count, data, running, ovf);
    modport host (output cmd_wr, opcode, cc, data_wr, wdata, inc_evt,
                  dec_evt, input count, data, running, ovf);
endinterface
`default_nettype wire

/* File: rtl/pmc_pkg.sv */
`default_nettype none
`include "pmc_regs.svh"
package pmc_pkg;
    // opcode field of a command register
    typedef enum logic [3:0] {
        PMC_OPC_STOP = `PMC_OP_STOP,
        PMC_OPC_START = `PMC_OP_START,
        PMC_OPC_SAMPLE = `PMC_OP_SAMPLE,
        PMC_OPC_RESET = `PMC_OP_RESET,
        PMC_OPC_SAMP_RST = `PMC_OP_SAMP_RST,
        PMC_OPC_PRELOAD = `PMC_OP_PRELOAD
    } pmc_opcode_t;
    typedef logic [31:0] pmc_word_t;
endpackage
`default_nettype wire

/* File: rtl/pmc_regs.svh */
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
// counter count and synchroniser width
`define PMC_NUM_CTR 2
`define PMC_SYNC_W 4
// register byte addresses (low address byte decoded)
`define PMC_ADDR_CMD0 8'h00
`define PMC_ADDR_DATA0 8'h04
`define PMC_ADDR_COUNT0 8'h08
`define PMC_CTR_STRIDE 8'h10
`define PMC_ADDR_STATUS 8'h20
`define PMC_ADDR_INT_CLR 8'h24
`define PMC_ADDR_INT_EN 8'h28
// command register fields
`define PMC_OPC_HI 19
`define PMC_OPC_LO 16
`define PMC_CC_HI 23
`define PMC_CC_LO 21
`define PMC_CMD_RSVD_MASK 32'hFFFF_7FFF
`define PMC_CC_FALSE 3'h0
// opcodes
`define PMC_OP_STOP 4'h0
`define PMC_OP_START 4'h1
`define PMC_OP_SAMPLE 4'h2
`define PMC_OP_RESET 4'h4
`define PMC_OP_SAMP_RST 4'h6
`define PMC_OP_PRELOAD 4'hF
// status register fields
`define PMC_STS_RUN_LO 8
// data constants and reset values
`define PMC_WORD_ZERO 32'h0000_0000
`define PMC_WORD_ONES 32'hFFFF_FFFF
`define PMC_WORD_ONE 32'h0000_0001
`define PMC_HTRANS_NONSEQ 2'h2
`endif

/* File: rtl/pmc_sync.sv */
`default_nettype none
`include "pmc_regs.svh"
// three-stage input synchroniser, change taken when stages two and three agree
module pmc_sync (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [`PMC_SYNC_W-1:0] async_in,
    output var logic [`PMC_SYNC_W-1:0] level_out
);
    genvar b;
    generate
        for (b = 0; b < `PMC_SYNC_W; b++) begin : g_bit
            logic s1_ff; // metastable stage, read only by s2
            logic s2_ff;
            logic s3_ff;
            logic lvl_ff; // filtered level
            // shift chain; lvl only moves on agreement
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                    s3_ff <= 1'b0;
                    lvl_ff <= 1'b0;
                end else begin
                    s1_ff <= async_in[b];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    // a one-cycle glitch in s2 is not taken
                    if (s2_ff == s3_ff) begin
                        lvl_ff <= s3_ff;
                    end
                end
            end
            assign level_out[b] = lvl_ff;
        end
    endgenerate
endmodule // pmc_sync
`default_nettype wire

/* File: rtl/pmc_top.sv */
// Contract
// - stop code holds count, ignores events
// - start code counts increment and decrement events
// - duration events count every clock while true; a level change lasting one clock is filtered out by the synchroniser
// - sample copies count, counter keeps running
// - sample writes data only when code false
// - reset code clears counter, leaves stopped
// - 32-bit counter, wrap sets overflow flag
// - sample-and-restart samples then restarts counting
// - preload loads counter from data register
// - running counter continues after preload
// - condition code zero means no compare
//
// The AHB-Lite register port was decided locally.
`default_nettype none
`include "pmc_regs.svh"
module pmc_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output var logic [31:0] hrdata,
    output var logic hreadyout,
    output var logic hresp,
    input wire logic [`PMC_NUM_CTR-1:0] inc_evt_in,
    input wire logic [`PMC_NUM_CTR-1:0] dec_evt_in,
    output var logic irq
);
    logic wr_ph_ff; // write data phase pending
    logic rd_ph_ff; // read data phase, wait state
    logic [7:0] addr_ff; // latched low address byte
    logic [31:0] hrdata_ff; // read data
    logic hreadyout_ff; // ready back to master
    logic [`PMC_NUM_CTR-1:0] ovf_sts_ff; // sticky overflow status
    logic [`PMC_NUM_CTR-1:0] int_en_ff; // interrupt enables
    logic irq_ff; // registered interrupt
    logic accept; // address phase taken
    logic [`PMC_SYNC_W-1:0] evt_lvl; // synchronised events
    logic [`PMC_NUM_CTR-1:0] ovf_pulse; // wrap pulses from counters
    logic [`PMC_NUM_CTR-1:0] run_vec; // running flags
    logic [`PMC_NUM_CTR-1:0] clr_vec; // clear strobes
    pmc_pkg::pmc_word_t cmd_rd [`PMC_NUM_CTR]; // command readback
    pmc_pkg::pmc_word_t data_rd [`PMC_NUM_CTR]; // data readback
    pmc_pkg::pmc_word_t count_rd [`PMC_NUM_CTR]; // count readback
    logic [31:0] nxt_hrdata; // read mux output

    // only nonseq transfers are used; seq treated alike, busy/idle ignored
    assign accept = hsel && hready && htrans[1];

    // event pins come from outside the clock domain
    pmc_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({dec_evt_in, inc_evt_in}),
        .level_out(evt_lvl)
    );

    // address phase capture and data phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_ff <= 1'b0;
            rd_ph_ff <= 1'b0;
            addr_ff <= 8'h00;
        end else begin
            if (accept) begin
                addr_ff <= haddr[7:0];
            end
            // write data phase lasts one cycle, no wait
            wr_ph_ff <= accept && hwrite;
            // read inserts one wait so a write just before is visible
            rd_ph_ff <= accept && !hwrite;
        end
    end

    // ready drops for the first read data phase cycle only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b1;
        end else begin
            hreadyout_ff <= !(accept && !hwrite);
        end
    end

    // per-counter glue
    genvar i;
    generate
        for (i = 0; i < `PMC_NUM_CTR; i++) begin : g_ctr
            localparam logic [7:0] A_CMD =
                8'(`PMC_ADDR_CMD0 + i * `PMC_CTR_STRIDE);
            localparam logic [7:0] A_DATA =
                8'(`PMC_ADDR_DATA0 + i * `PMC_CTR_STRIDE);
            logic [31:0] cmd_ff; // stored command word
            logic cmd_hit; // this command register written
            pmc_ctr_if cif ();

            assign cmd_hit = wr_ph_ff && (addr_ff == A_CMD);

            // command word store; executes the opcode the same cycle
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cmd_ff <= `PMC_WORD_ZERO;
                end else if (cmd_hit) begin
                    cmd_ff <= hwdata & `PMC_CMD_RSVD_MASK;
                end
            end

            assign cif.cmd_wr = cmd_hit;
            assign cif.opcode = hwdata[`PMC_OPC_HI:`PMC_OPC_LO];
            assign cif.cc = hwdata[`PMC_CC_HI:`PMC_CC_LO];
            assign cif.data_wr = wr_ph_ff && (addr_ff == A_DATA);
            assign cif.wdata = hwdata;
            assign cif.inc_evt = evt_lvl[i];
            assign cif.dec_evt = evt_lvl[i + `PMC_NUM_CTR];

            pmc_counter u_ctr (
                .hclk(hclk),
                .hresetn(hresetn),
                .cif(cif)
            );

            assign cmd_rd[i] = cmd_ff;
            assign data_rd[i] = cif.data;
            assign count_rd[i] = cif.count;
            assign ovf_pulse[i] = cif.ovf;
            assign run_vec[i] = cif.running;
        end
    endgenerate

    // clear strobes from the write-only clear register
    assign clr_vec = (wr_ph_ff && addr_ff == `PMC_ADDR_INT_CLR) ?
                     hwdata[`PMC_NUM_CTR-1:0] : '0;

    // sticky overflow, set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_sts_ff <= '0;
        end else begin
            ovf_sts_ff <= (ovf_sts_ff & ~clr_vec) | ovf_pulse;
        end
    end

    // interrupt enable register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_en_ff <= '0;
        end else if (wr_ph_ff && addr_ff == `PMC_ADDR_INT_EN) begin
            int_en_ff <= hwdata[`PMC_NUM_CTR-1:0];
        end
    end

    // level interrupt, one cycle behind the status bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(ovf_sts_ff & int_en_ff);
        end
    end

    // read mux; unmapped and write-only offsets read zero
    always_comb begin
        nxt_hrdata = `PMC_WORD_ZERO;
        for (int k = 0; k < `PMC_NUM_CTR; k++) begin
            if (addr_ff == 8'(`PMC_ADDR_CMD0 + k * `PMC_CTR_STRIDE)) begin
                nxt_hrdata = cmd_rd[k];
            end
            if (addr_ff == 8'(`PMC_ADDR_DATA0 + k * `PMC_CTR_STRIDE)) begin
                nxt_hrdata = data_rd[k];
            end
            if (addr_ff == 8'(`PMC_ADDR_COUNT0 + k * `PMC_CTR_STRIDE)) begin
                nxt_hrdata = count_rd[k];
            end
        end
        if (addr_ff == `PMC_ADDR_STATUS) begin
            nxt_hrdata[`PMC_NUM_CTR-1:0] = ovf_sts_ff;
            nxt_hrdata[`PMC_STS_RUN_LO +: `PMC_NUM_CTR] = run_vec;
        end
        if (addr_ff == `PMC_ADDR_INT_EN) begin
            nxt_hrdata[`PMC_NUM_CTR-1:0] = int_en_ff;
        end
    end

    // read data loaded in the wait cycle, held until the next read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= `PMC_WORD_ZERO;
        end else if (rd_ph_ff && !hreadyout_ff) begin
            hrdata_ff <= nxt_hrdata;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    // always okay
    assign hresp = 1'b0;
    assign irq = irq_ff;
endmodule // pmc_top
`default_nettype wire
